/* File: core/gp_timer_block.sv */
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
// Timer block with two 16-bit counters that may be joined into one 32-bit counter.
module gp_timer_block
  import gp_timer_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Processor halt from the debugger.
  input wire logic debug_halt_i,
  // Time-out pin pulses and time-out or match trigger pulses; bit 0 is counter A, bit 1 counter B.
  output logic [1:0] capture_compare_pin_o,
  output logic [1:0] trigger_o
);

  // Configuration, mode and control state.
  logic [2:0] cfg_q;
  mode_s mode_q [2];
  logic [1:0] en_q;
  logic [1:0] stall_q;
  logic [11:0] imr_q;
  logic [11:0] ris_q;
  logic [11:0] ev_q;
  // Load, prescale and match registers; act holds the live match.
  logic [15:0] ilr_q [2];
  logic [7:0] pr_q [2];
  logic [15:0] match_q [2];
  logic [7:0] pmatch_q [2];
  logic [15:0] mact_q [2];
  logic [7:0] pmact_q [2];
  // Counters and their snapshots.
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic [7:0] ps_q [2];
  logic [7:0] ps_d [2];
  logic [15:0] cap_q [2];
  logic [7:0] pss_q [2];
  // Halt synchroniser.
  logic halt_meta_q;
  logic halt_q;
  // Decoded strobes.
  logic w_cfg, w_ctrl, w_imr, w_icr, w_ev;
  logic [1:0] w_mode, w_ilr, w_pr, w_match, w_pmr, w_val;
  logic [1:0] ilr_wr, match_wr, start;
  logic [15:0] hdat [2];
  // Counting state per counter.
  logic joined;
  logic [1:0] run, tmo, hit, to_ev, m_ev, snap;
  logic [23:0] ext [2];
  logic [23:0] lim [2];
  logic [23:0] mext [2];
  logic [31:0] wide, wide_ilr, wide_m, wide_d;
  logic [11:0] st_set;
  logic [31:0] rd_val;

  // True when a strobe hits a given offset.
  function automatic logic acc(input logic stb, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    acc = stb && (a == off);
  endfunction : acc

  // True when the prescaler is the low part of the count.
  function automatic logic ps_low(input mode_s m);
    ps_low = !m.count_up && (m.mode == MODE_ONESHOT || m.mode == MODE_PERIODIC);
  endfunction : ps_low

  // Anything but the split code runs the pair joined.
  assign joined = (cfg_q != CFG_SPLIT);

  // Register write decode; in joined mode counter A load and match writes also fill B's half.
  always_comb begin
    w_cfg = acc(we_i, addr_i, OFF_CFG);
    w_ctrl = acc(we_i, addr_i, OFF_CTRL);
    w_imr = acc(we_i, addr_i, OFF_IMR);
    w_icr = acc(we_i, addr_i, OFF_ICR);
    w_ev = acc(we_i, addr_i, OFF_EV);
    for (int i = 0; i < 2; i++) begin
      w_mode[i] = acc(we_i, addr_i, OFF_MODE[i]);
      w_ilr[i] = acc(we_i, addr_i, OFF_ILR[i]);
      w_pr[i] = acc(we_i, addr_i, OFF_PR[i]);
      w_match[i] = acc(we_i, addr_i, OFF_MATCH[i]);
      w_pmr[i] = acc(we_i, addr_i, OFF_PMR[i]);
      w_val[i] = acc(we_i, addr_i, OFF_VAL[i]);
      start[i] = w_ctrl && wdata_i[CTRL_EN_POS[i]] && !en_q[i];
    end
    // Upper half of a joined write goes to counter B.
    ilr_wr[0] = w_ilr[0];
    match_wr[0] = w_match[0];
    hdat[0] = wdata_i[15:0];
    ilr_wr[1] = w_ilr[1] || (joined && w_ilr[0]);
    match_wr[1] = w_match[1] || (joined && w_match[0]);
    hdat[1] = joined ? wdata_i[31:16] : wdata_i[15:0];
  end

  // Time-out, match and next count for each counter.
  always_comb begin
    wide = {cnt_q[1], cnt_q[0]};
    wide_ilr = {ilr_q[1], ilr_q[0]};
    wide_m = {mact_q[1], mact_q[0]};
    wide_d = wide;
    st_set = 12'h000;
    for (int i = 0; i < 2; i++) begin
      ext[i] = {ps_q[i], cnt_q[i]};
      lim[i] = {pr_q[i], ilr_q[i]};
      mext[i] = {pmact_q[i], mact_q[i]};
      cnt_d[i] = cnt_q[i];
      ps_d[i] = ps_q[i];
      // Counter B is idle when joined; each counter keeps its own mode.
      run[i] = en_q[i] && (mode_q[i].mode != MODE_OFF) && !(stall_q[i] && halt_q)
               && !(joined && i == 1);
      if (joined) begin
        // The joined pair has no prescaler.
        tmo[i] = mode_q[i].count_up ? (wide == wide_ilr) : (wide == 32'h0);
        hit[i] = (wide == wide_m);
      end else if (ps_low(mode_q[i])) begin
        tmo[i] = (ext[i] == 24'h0);
        hit[i] = (ext[i] == mext[i]);
      end else begin
        tmo[i] = mode_q[i].count_up ? (ext[i] == lim[i]) : (ext[i] == 24'h0);
        hit[i] = (ext[i] == mext[i]);
      end
      // Start value, software loads, then reload or count.
      if (start[i]) begin
        {ps_d[i], cnt_d[i]} = mode_q[i].count_up ? 24'h0 : lim[i];
      end else if (w_val[i]) begin
        cnt_d[i] = wdata_i[15:0];
      end else if (en_q[i] && !mode_q[i].count_up && !mode_q[i].load_defer
                   && (w_ilr[i] || w_pr[i])) begin
        // An undeferred load write while counting down lands at once.
        if (w_ilr[i]) begin
          cnt_d[i] = wdata_i[15:0];
        end
        if (w_pr[i]) begin
          ps_d[i] = wdata_i[7:0];
        end
      end else if (run[i] && tmo[i]) begin
        {ps_d[i], cnt_d[i]} = mode_q[i].count_up ? 24'h0 : lim[i];
      end else if (run[i] && ps_low(mode_q[i])) begin
        // Main count steps only when the prescaler underflows.
        if (ps_q[i] == 8'h00) begin
          cnt_d[i] = cnt_q[i] - 16'h0001;
          ps_d[i] = pr_q[i];
        end else begin
          ps_d[i] = ps_q[i] - 8'h01;
        end
      end else if (run[i]) begin
        // Prescaler extends the count above bit 15.
        {ps_d[i], cnt_d[i]} = mode_q[i].count_up ? ext[i] + 24'h1 : ext[i] - 24'h1;
      end
      to_ev[i] = run[i] && tmo[i];
      m_ev[i] = run[i] && hit[i] && mode_q[i].match_irq_en;
      snap[i] = (mode_q[i].mode == MODE_PERIODIC) && mode_q[i].snapshot_en;
      st_set[ST_TO_POS[i]] = to_ev[i] && !mode_q[i].to_irq_dis;
      st_set[ST_M_POS[i]] = m_ev[i];
    end
    // The joined pair counts as one 32-bit value under counter A.
    if (joined) begin
      if (start[0]) begin
        wide_d = mode_q[0].count_up ? 32'h0 : wide_ilr;
      end else if (w_val[0]) begin
        wide_d = wdata_i;
      end else if (en_q[0] && !mode_q[0].count_up && !mode_q[0].load_defer && w_ilr[0]) begin
        wide_d = wdata_i;
      end else if (run[0] && tmo[0]) begin
        wide_d = mode_q[0].count_up ? 32'h0 : wide_ilr;
      end else if (run[0]) begin
        wide_d = mode_q[0].count_up ? wide + 32'h1 : wide - 32'h1;
      end
      cnt_d[0] = wide_d[15:0];
      cnt_d[1] = wide_d[31:16];
      ps_d[0] = ps_q[0];
      ps_d[1] = ps_q[1];
    end
  end

  // Two-stage synchroniser for the halt level.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_meta_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      halt_meta_q <= debug_halt_i;
      halt_q <= halt_meta_q;
    end
  end

  // Configuration, mode, mask, trigger-event and stall bits.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
      imr_q <= 12'h000;
      ev_q <= 12'h000;
      stall_q <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        mode_q[i] <= mode_s'(12'h000);
      end
    end else begin
      if (w_cfg) begin
        cfg_q <= wdata_i[2:0];
      end
      if (w_imr) begin
        imr_q <= wdata_i[11:0] & ST_MASK;
      end
      if (w_ev) begin
        ev_q <= wdata_i[11:0] & ST_MASK;
      end
      for (int i = 0; i < 2; i++) begin
        if (w_ctrl) begin
          stall_q[i] <= wdata_i[CTRL_STALL_POS[i]];
        end
        if (w_mode[i]) begin
          mode_q[i] <= mode_s'(wdata_i[11:0] & MODE_WMASK);
        end
      end
    end
  end

  // Enable bits; a one-shot time-out clears its own enable.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (w_ctrl) begin
          en_q[i] <= wdata_i[CTRL_EN_POS[i]];
        end else if (to_ev[i] && mode_q[i].mode == MODE_ONESHOT) begin
          en_q[i] <= 1'b0;
        end
      end
    end
  end

  // Load, prescale and match registers with their live match copies.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        ilr_q[i] <= CNT_RST;
        pr_q[i] <= PS_RST;
        match_q[i] <= CNT_RST;
        mact_q[i] <= CNT_RST;
        pmatch_q[i] <= PS_RST;
        pmact_q[i] <= PS_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ilr_wr[i]) begin
          ilr_q[i] <= hdat[i];
        end
        if (w_pr[i]) begin
          pr_q[i] <= wdata_i[7:0];
        end
        if (match_wr[i]) begin
          match_q[i] <= hdat[i];
        end
        if (w_pmr[i]) begin
          pmatch_q[i] <= wdata_i[7:0];
        end
        // Deferred match values go live at the next time-out of the owning counter.
        if (match_wr[i] && !mode_q[joined ? 0 : i].match_defer) begin
          mact_q[i] <= hdat[i];
        end else if (to_ev[joined ? 0 : i] && mode_q[joined ? 0 : i].match_defer) begin
          mact_q[i] <= match_q[i];
        end
        if (w_pmr[i] && !mode_q[i].match_defer) begin
          pmact_q[i] <= wdata_i[7:0];
        end else if (to_ev[i] && mode_q[i].match_defer) begin
          pmact_q[i] <= pmatch_q[i];
        end
      end
    end
  end

  // Counters and prescalers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= CNT_RST;
        ps_q[i] <= PS_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= cnt_d[i];
        ps_q[i] <= ps_d[i];
      end
    end
  end

  // Capture and prescale snapshot follow the count, or freeze it at time-out.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        cap_q[i] <= CNT_RST;
        pss_q[i] <= PS_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (snap[joined ? 0 : i] && !start[joined ? 0 : i]) begin
          if (to_ev[joined ? 0 : i]) begin
            cap_q[i] <= cnt_q[i];
            pss_q[i] <= ps_q[i];
          end
        end else begin
          cap_q[i] <= cnt_d[i];
          pss_q[i] <= ps_d[i];
        end
      end
    end
  end

  // Sticky raw status; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ris_q <= 12'h000;
    end else begin
      ris_q <= (ris_q & ~(w_icr ? wdata_i[11:0] : 12'h000)) | st_set;
    end
  end

  // Time-out pin pulse and trigger pulse per counter.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capture_compare_pin_o <= 2'b00;
      trigger_o <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        capture_compare_pin_o[i] <= to_ev[i];
        trigger_o[i] <= (to_ev[i] && ev_q[ST_TO_POS[i]]) || (m_ev[i] && ev_q[ST_M_POS[i]]);
      end
    end
  end

  // Read mux; joined counter A load, match, capture and value registers show the full 32-bit value.
  always_comb begin
    rd_val = 32'h0;
    if (addr_i == OFF_CFG) begin
      rd_val = {29'h0, cfg_q};
    end
    if (addr_i == OFF_CTRL) begin
      for (int i = 0; i < 2; i++) begin
        rd_val[CTRL_EN_POS[i]] = en_q[i];
        rd_val[CTRL_STALL_POS[i]] = stall_q[i];
      end
    end
    if (addr_i == OFF_IMR) begin
      rd_val = {20'h0, imr_q};
    end
    if (addr_i == OFF_RIS) begin
      rd_val = {20'h0, ris_q};
    end
    if (addr_i == OFF_MIS) begin
      rd_val = {20'h0, ris_q & imr_q};
    end
    if (addr_i == OFF_EV) begin
      rd_val = {20'h0, ev_q};
    end
    for (int i = 0; i < 2; i++) begin
      if (addr_i == OFF_MODE[i]) begin
        rd_val = {20'h0, mode_q[i]};
      end
      if (addr_i == OFF_ILR[i]) begin
        rd_val = (joined && i == 0) ? wide_ilr : {16'h0, ilr_q[i]};
      end
      if (addr_i == OFF_MATCH[i]) begin
        rd_val = (joined && i == 0) ? {match_q[1], match_q[0]} : {16'h0, match_q[i]};
      end
      if (addr_i == OFF_PR[i]) begin
        rd_val = {24'h0, pr_q[i]};
      end
      if (addr_i == OFF_PMR[i]) begin
        rd_val = {24'h0, pmatch_q[i]};
      end
      if (addr_i == OFF_CAP[i]) begin
        rd_val = (joined && i == 0) ? {cap_q[1], cap_q[0]} : {16'h0, cap_q[i]};
      end
      if (addr_i == OFF_VAL[i]) begin
        rd_val = (joined && i == 0) ? wide : {8'h0, ext[i]};
      end
      if (addr_i == OFF_PSS[i]) begin
        rd_val = {24'h0, pss_q[i]};
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= re_i ? rd_val : 32'h0;
    end
  end

  // Checks on counter A behaviour, and covers on both counters.
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  cfg_split_a: assert property (
    w_cfg && wdata_i[2:0] == CFG_SPLIT |=> !joined ##1 1'b1)
    else $error("split config not taken");
  oneshot_stop_a: assert property (
    to_ev[0] && mode_q[0].mode == MODE_ONESHOT && !w_ctrl |=> !en_q[0])
    else $error("one-shot kept running");
  periodic_go_a: assert property (
    to_ev[0] && mode_q[0].mode == MODE_PERIODIC && !we_i |=> en_q[0] ##1 en_q[0] || we_i || to_ev[0])
    else $error("periodic counter stopped");
  down_reload_a: assert property (
    to_ev[0] && !joined && !mode_q[0].count_up && !we_i
    |=> cnt_q[0] == $past(ilr_q[0]) && ps_q[0] == $past(pr_q[0]))
    else $error("down reload wrong");
  up_reload_a: assert property (
    to_ev[0] && mode_q[0].count_up && !we_i |=> cnt_q[0] == 16'h0000)
    else $error("up reload not zero");
  prescale_div_a: assert property (
    run[0] && !joined && ps_low(mode_q[0]) && ps_q[0] != 8'h00 && !we_i |=> $stable(cnt_q[0]))
    else $error("counter stepped before underflow");
  raw_timeout_a: assert property (
    to_ev[0] && !mode_q[0].to_irq_dis |=> ris_q[ST_TO_POS[0]] ##1 (ris_q[ST_TO_POS[0]] || $past(w_icr)))
    else $error("time-out flag not held");
  timeout_mute_a: assert property (
    to_ev[0] && mode_q[0].to_irq_dis && !ris_q[ST_TO_POS[0]] |=> !ris_q[ST_TO_POS[0]])
    else $error("disabled time-out set flag");
  match_gate_a: assert property (
    !mode_q[0].match_irq_en && !ris_q[ST_M_POS[0]] |=> !ris_q[ST_M_POS[0]])
    else $error("match flag set while disabled");
  value_load_a: assert property (
    w_val[0] && !joined |=> cnt_q[0] == $past(wdata_i[15:0]))
    else $error("value write not loaded");
  stall_hold_a: assert property (
    en_q[0] && stall_q[0] && halt_q && !we_i |=> $stable(cnt_q[0]) && $stable(ps_q[0]))
    else $error("counter moved during halt");

  periodic_to_c: cover property (to_ev[0] && mode_q[0].mode == MODE_PERIODIC);
  oneshot_to_c: cover property (to_ev[1] && mode_q[1].mode == MODE_ONESHOT);
  match_hit_c: cover property (m_ev[0]);
  joined_to_c: cover property (to_ev[0] && joined);

endmodule : gp_timer_block

/* File: inc/gp_timer_pkg.sv */
// Register map, field layout and reset values of the general-purpose timer block.
//
// Functional notes
// - Two 16-bit counters, joinable as 32-bit.
// - Prescaler works only with counters separate.
// - Prescaler low part down, upper part up.
// - Other modes: prescaler always upper part.
// - Joined: one mode; separate: independent modes.
// - Reset clears control, counters all ones.
// - Config value 0x4 selects separate counters.
// - Time-out zero down, load value up.
// - Mode field and direction bit per counter.
// - Enable starts from zero or load value.
// - Time-out reloads load value or zero.
// - One-shot stops and clears enable; periodic continues.
// - Periodic snapshot captures count at time-out.
// - Time-out raw flag sticky; mask gives masked.
// - Time-out disable bit suppresses raw flag.
// - Match flag only while match enable set.
// - Time-out drives pin pulse and trigger.
// - Load writes: immediate or deferred to time-out.
// - Value register write loads counter next clock.
// - Match writes: immediate or deferred to time-out.
// - Debug stall freezes counter during halt.
package gp_timer_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MODE [2] = '{8'h04, 8'h08};
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_IMR = 8'h18;
  localparam logic [7:0] OFF_RIS = 8'h1C;
  localparam logic [7:0] OFF_MIS = 8'h20;
  localparam logic [7:0] OFF_ICR = 8'h24;
  localparam logic [7:0] OFF_ILR [2] = '{8'h28, 8'h2C};
  localparam logic [7:0] OFF_MATCH [2] = '{8'h30, 8'h34};
  localparam logic [7:0] OFF_PR [2] = '{8'h38, 8'h3C};
  localparam logic [7:0] OFF_PMR [2] = '{8'h40, 8'h44};
  localparam logic [7:0] OFF_CAP [2] = '{8'h48, 8'h4C};
  localparam logic [7:0] OFF_VAL [2] = '{8'h50, 8'h54};
  localparam logic [7:0] OFF_PSS [2] = '{8'h5C, 8'h60};
  localparam logic [7:0] OFF_EV = 8'h6C;
  // Block configuration codes.
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [2:0] CFG_RST = 3'h0;
  // Control register bit positions, index 0 is counter A.
  localparam int CTRL_EN_POS [2] = '{0, 8};
  localparam int CTRL_STALL_POS [2] = '{1, 9};
  // Status, mask, clear and trigger-event bit positions.
  localparam int ST_TO_POS [2] = '{0, 8};
  localparam int ST_M_POS [2] = '{4, 11};
  localparam logic [11:0] ST_MASK = 12'h911;
  // Counter mode register writable bits.
  localparam logic [11:0] MODE_WMASK = 12'hDB3;
  // Reset values.
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam logic [7:0] PS_RST = 8'h00;
  // Counter mode field codes.
  typedef enum logic [1:0] {MODE_OFF, MODE_ONESHOT, MODE_PERIODIC, MODE_FREE} cmode_e;
  // Counter mode register layout.
  typedef struct packed {
    logic to_irq_dis;
    logic match_defer;
    logic rsvd9;
    logic load_defer;
    logic snapshot_en;
    logic rsvd6;
    logic match_irq_en;
    logic count_up;
    logic [1:0] rsvd3;
    cmode_e mode;
  } mode_s;
endpackage : gp_timer_pkg

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// Self-checking testbench for the general-purpose timer block.
module testbench;
  import gp_timer_pkg::*;
  // Stimulus towards the design.
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic debug_halt_i = 1'b0;
  // Responses of the design.
  logic [31:0] rdata_o;
  logic [1:0] capture_compare_pin_o;
  logic [1:0] trigger_o;
  // Scoreboard counters, random state and scratch values.
  int fails = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h1AFF;
  logic [31:0] v;
  logic [31:0] w;
  int lv;
  int pv;
  int c;
  // Addresses read after reset, unmapped last, and the values they must show.
  logic [7:0] ra [8] = '{OFF_CFG, OFF_CTRL, OFF_ILR[0], OFF_VAL[0], OFF_PR[0], OFF_PSS[0], OFF_CAP[0], 8'hF0};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0};

  // Device under test.
  gp_timer_block i_gp_timer_block (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .we_i(we_i),
    .re_i(re_i),
    .rdata_o(rdata_o),
    .debug_halt_i(debug_halt_i),
    .capture_compare_pin_o(capture_compare_pin_o),
    .trigger_o(trigger_o)
  );

  // Clock of 10 ns period.
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Next value of the pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge ref_clk_i);
    we_i <= 1'b0;
  endtask : wr

  // One-cycle register read; data is taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge ref_clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // Counts cycles until the next time-out pulse of one counter, with a bound.
  task automatic pulse(input int i, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (capture_compare_pin_o[i] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      chk("pulse wait", 32'h1, 32'h0);
    end
  endtask : pulse

  // Programs one counter, starts it and measures the time-out period.
  task automatic run(input int i, input logic [31:0] md, input logic [31:0] ld, input logic [31:0] ps,
                     input int per, input logic trg);
    int n;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_MODE[i], md);
    wr(OFF_ILR[i], ld);
    wr(OFF_PR[i], ps);
    wr(OFF_CTRL, 32'h1 << CTRL_EN_POS[i]);
    pulse(i, n);
    chk("trigger", {31'h0, trg}, {31'h0, trigger_o[i]});
    pulse(i, n);
    chk("period", per, n);
  endtask : run

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    fails++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Reset state and an unmapped address.
    foreach (ra[k]) begin
      rd(ra[k], v);
      chk("reset value", rv[k], v);
    end
    // Joined counter holds a full 32-bit load value.
    wr(OFF_ILR[0], 32'h12345678);
    rd(OFF_ILR[0], v);
    chk("joined load", 32'h12345678, v);
    // Joined down count ignores the prescaler; joined up count reaches the load value.
    run(0, 32'h2, 32'h5, 32'h3, 6, 1'b0);
    run(0, 32'h12, 32'h7, 32'h0, 8, 1'b0);
    // One-shot stops and clears its own enable.
    wr(OFF_CTRL, 32'h0);
    wr(OFF_MODE[0], 32'h1);
    wr(OFF_ILR[0], 32'h3);
    wr(OFF_CTRL, 32'h1);
    pulse(0, c);
    rd(OFF_CTRL, v);
    chk("one-shot enable", 32'h0, v & 32'h1);
    // Separate counters, triggers on time-out, time-out A unmasked.
    wr(OFF_CFG, 32'h4);
    rd(OFF_CFG, v);
    chk("config", 32'h4, v);
    wr(OFF_EV, 32'h101);
    wr(OFF_IMR, 32'h1);
    // Random load and prescale, both counters, down periodic.
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      lv = 1 + int'(seed[1:0]);
      pv = int'(seed[5:4]);
      run(k % 2, 32'h2, lv, pv, (lv + 1) * (pv + 1), 1'b1);
    end
    // Three-cycle down period on counter A and an up count on counter B.
    run(0, 32'h2, 32'h2, 32'h0, 3, 1'b1);
    run(1, 32'h12, 32'h9, 32'h0, 10, 1'b1);
    // Sticky raw flags, masked flag and clearing; match flags untouched so far.
    wr(OFF_CTRL, 32'h0);
    rd(OFF_RIS, v);
    chk("raw status", 32'h101, v & 32'h911);
    rd(OFF_MIS, v);
    chk("masked status", 32'h1, v & 32'h911);
    wr(OFF_ICR, 32'h101);
    rd(OFF_RIS, v);
    chk("cleared status", 32'h0, v & 32'h911);
    // Time-out flag suppressed while the pin still pulses.
    run(0, 32'h802, 32'h3, 32'h0, 4, 1'b1);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_RIS, v);
    chk("suppressed flag", 32'h0, v & 32'h1);
    // Periodic snapshot holds the count seen at time-out while the counter runs on.
    run(0, 32'h82, 32'h3, 32'h0, 4, 1'b1);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CAP[0], v);
    chk("snapshot", 32'h0, v);
    // Match flag of counter B with match enabled.
    wr(OFF_MATCH[1], 32'h5);
    wr(OFF_PMR[1], 32'h0);
    run(1, 32'h22, 32'h14, 32'h0, 21, 1'b1);
    rd(OFF_RIS, v);
    chk("match flag", 32'h800, v & 32'h800);
    // Value write reloads the running counter.
    wr(OFF_CTRL, 32'h0);
    wr(OFF_MODE[0], 32'h2);
    wr(OFF_ILR[0], 32'hFFFF);
    wr(OFF_PR[0], 32'h0);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_VAL[0], 32'h200);
    rd(OFF_VAL[0], v);
    chk("value load", 32'h1, {31'h0, v <= 32'h200 && v > 32'h1F0});
    // Debug stall freezes the count and releases it again.
    wr(OFF_CTRL, 32'h3);
    debug_halt_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(OFF_VAL[0], v);
    repeat (8) @(posedge ref_clk_i);
    rd(OFF_VAL[0], w);
    chk("stalled value", v, w);
    debug_halt_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rd(OFF_VAL[0], w);
    chk("resumed value", 32'h1, {31'h0, w < v});
    end_sim();
  end
endmodule : testbench
